/* pkg/dac_latch_pkg.sv */
package dac_latch_pkg;
  localparam int WORD_W = 16;
  localparam int SEG_BITS = 4;
  localparam int SEG_N = 15;
  localparam int LADDER_W = 12;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] INREG_RESET = 16'h0000;
  localparam int FULL_SCALE = 65536;
  localparam logic HAS_LOAD_PIN = 1'b1;
endpackage

/* rtl/serial_dac_input_latch.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Device is slave; master clocks, starts frames.
// - Chip select high: clock and data ignored.
// - Data sampled on rising clock, MSB first.
// - Chip select rise copies shift to input.
// - Extra clocks: last sixteen bits kept.
// - Short word keeps older unshifted bits.
// - Input register and latch reset to zero.
// - Shift register not reset at power-up.
// - No load pin: latch follows input load.
// - Load low after frame updates latch.
// - Load tied low updates after input load.
// - Top four bits decode to fifteen segments.
// - Latch code is straight unsigned binary.
// - Load low, chip select high: latch tracks input register.
module serial_dac_input_latch
  import dac_latch_pkg::*;
#(
  parameter int W = WORD_W,
  parameter bit LOAD_PIN = HAS_LOAD_PIN
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic LATCH_LOAD_N,
  input wire logic WORD_READY,
  output logic WORD_VALID,
  output logic [W-1:0] WORD_DATA,
  output logic [W-1:0] LATCH_CODE,
  output logic [SEG_N-1:0] SEGMENT_SWITCHES,
  output logic [LADDER_W-1:0] LADDER_SWITCHES
);
  logic [2:0] cs_s, sck_s, sdi_s, ld_s;
  logic [W-1:0] shift;
  logic [W-1:0] input_reg;
  logic sck_rise, cs_rise, cs_low, load_low;
  // Two-entry buffer of words handed to the downstream user.
  logic [W-1:0] buf_mem [2];
  logic [1:0] buf_cnt;
  logic buf_wp, buf_rp;
  logic buf_push, buf_pop;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      ld_s <= 3'h7;
    end else begin
      cs_s <= {cs_s[1:0], CS_N};
      sck_s <= {sck_s[1:0], SCLK};
      sdi_s <= {sdi_s[1:0], SDI};
      ld_s <= {ld_s[1:0], LATCH_LOAD_N};
    end
  end

  // Stage 0 only feeds stage 1; edges are found between stages 1 and 2.
  assign cs_low = ~cs_s[1];
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign load_low = ~ld_s[1];

  // The shift register has no reset, as in the converter itself.
  always_ff @(posedge CLK) begin
    if (cs_low && sck_rise) begin
      shift <= {shift[W-2:0], sdi_s[1]};
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      input_reg <= INREG_RESET;
    end else if (cs_rise) begin
      input_reg <= shift;
    end
  end

  // The latch follows the input register while load is low and chip select is high, so a tied-low
  // load gives an update one cycle after the chip select rise.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LATCH_CODE <= LATCH_RESET;
    end else if (!LOAD_PIN && cs_rise) begin
      LATCH_CODE <= shift;
    end else if (LOAD_PIN && load_low && cs_s[1]) begin
      LATCH_CODE <= input_reg;
    end
  end

  // Segment k closes when the top nibble exceeds k; thermometer code.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SEGMENT_SWITCHES <= '0;
      LADDER_SWITCHES <= '0;
    end else begin
      for (int k = 0; k < SEG_N; k++) begin
        SEGMENT_SWITCHES[k] <= (LATCH_CODE[W-1 -: SEG_BITS] > k[SEG_BITS-1:0]);
      end
      LADDER_SWITCHES <= LATCH_CODE[LADDER_W-1:0];
    end
  end

  // A stalled consumer holds words; a third word while full is dropped.
  assign buf_push = cs_rise && (buf_cnt != 2'd2);
  assign buf_pop = WORD_VALID && WORD_READY;
  assign WORD_VALID = (buf_cnt != 2'd0);
  assign WORD_DATA = buf_mem[buf_rp];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp] <= shift;
        buf_wp <= ~buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
endmodule

/* tb/serial_dac_input_latch_assertions.sv */
`timescale 1ns/1ns
module dac_chk (
  input wire logic CLK, ARST_N, CS_N, LATCH_LOAD_N, WORD_READY, WORD_VALID,
  input wire logic [15:0] WORD_DATA, LATCH_CODE,
  input wire logic [14:0] SEGMENT_SWITCHES,
  input wire logic [11:0] LADDER_SWITCHES);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_l; LADDER_SWITCHES == $past(LATCH_CODE[11:0]); endproperty
  a_l: assert property (p_l) else $error("ladder");
  property p_s; SEGMENT_SWITCHES == 15'((16'h1 << $past(LATCH_CODE[15:12])) - 1); endproperty
  a_s: assert property (p_s) else $error("segment");
  property p_v; $rose(WORD_VALID) |-> $past(CS_N); endproperty
  a_v: assert property (p_v) else $error("push");
  property p_h; WORD_VALID && !WORD_READY |=> $stable(WORD_DATA); endproperty
  a_h: assert property (p_h) else $error("hold");
  property p_k; LATCH_LOAD_N [*4] |=> $stable(LATCH_CODE); endproperty
  a_k: assert property (p_k) else $error("load");
  property p_c; !CS_N [*5] |=> $stable(LATCH_CODE); endproperty
  a_c: assert property (p_c) else $error("select");
  property p_r; disable iff (1'b0) !ARST_N |-> LATCH_CODE == 16'h0; endproperty
  a_r: assert property (p_r) else $error("reset");
  property p_t; $rose(WORD_VALID) && !$past(LATCH_LOAD_N, 4) |=> LATCH_CODE == $past(WORD_DATA); endproperty
  a_t: assert property (p_t) else $error("latch");
endmodule
bind serial_dac_input_latch dac_chk dac_chk_i (.*);

/* tb/spi_master_model.sv */
`timescale 1ns/1ns
module spi_master_model (
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic sdi = 1'b0);
  task automatic send(logic [31:0] w, int n);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= w[i];
      #160 sclk <= 1'b1;
      #160 sclk <= 1'b0;
    end
    #160 cs_n <= 1'b1;
    sdi <= ~sdi;
    // A shared bus may clock another slave while this one is deselected.
    #160 sclk <= 1'b1;
    #160 sclk <= 1'b0;
  endtask
endmodule

/* tb/tb_serial_dac_input_latch.sv */
`timescale 1ns/1ns
module tb_serial_dac_input_latch;
  logic CLK = 0, ARST_N, LATCH_LOAD_N = 1, WORD_READY = 0, CS_N, SCLK, SDI, WORD_VALID;
  logic [15:0] WORD_DATA, LATCH_CODE, sr, lat, q[$];
  logic [31:0] w;
  int failures = 0, n_checks = 0, n[6] = '{16, 20, 8, 5, 16, 16};
  always #20 CLK = ~CLK;
  spi_master_model spi_master_model_i (.cs_n(CS_N), .sclk(SCLK), .sdi(SDI));
  serial_dac_input_latch serial_dac_input_latch_i (.CLK, .ARST_N, .CS_N, .SCLK, .SDI,
    .LATCH_LOAD_N, .WORD_READY, .WORD_VALID, .WORD_DATA, .LATCH_CODE,
    .SEGMENT_SWITCHES(), .LADDER_SWITCHES());
  function automatic logic [15:0] nxt(int k);
    return k > 15 ? w[15:0] : (sr << k) | w[15:0];
  endfunction
  task automatic chk(logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) failures++;
    if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    // An edge from unknown to low makes the asynchronous reset take effect.
    ARST_N <= 1'b0;
    w = $urandom(32'h94e2414b);
    repeat (20) @(posedge CLK);
    chk(LATCH_CODE, 16'h0);
    ARST_N <= 1'b1;
    lat = 16'h0;
    foreach (n[i]) begin
      w = $urandom % (32'h1 << n[i]);
      if (i == 5) w = w & 32'hfff0;
      // Frame 4 models a load pin tied low; all others keep it high during the frame.
      LATCH_LOAD_N <= (i != 4);
      @(posedge CLK);
      spi_master_model_i.send(w, n[i]);
      sr = nxt(n[i]);
      if (i < 2) q.push_back(sr);
      chk(LATCH_CODE, (i == 4) ? sr : lat);
      LATCH_LOAD_N <= 1'b0;
      repeat (6) @(posedge CLK);
      chk(LATCH_CODE, sr);
      lat = sr;
      // The third word met a full buffer, so the head must still be the first.
      if (i == 2) begin
        chk({15'h0, WORD_VALID}, 16'h1);
        chk(WORD_DATA, q[0]);
        WORD_READY <= 1'b1;
        repeat (2) @(negedge CLK);
        chk(WORD_DATA, q[1]);
      end
    end
    end_sim();
  end
endmodule
